// ---- rtl/stpwm_pkg.sv ----
// package: constants, mode codes and carrier structs for the standard timer
package stpwm_pkg;

  localparam int CNT_W    = 16;
  localparam int COMPARATOR_P_VALUE_W   = 8;
  localparam int COMPARATOR_P_VALUE_LSB = 8;
  localparam int SEL_W    = 3;
  localparam int DIV_W    = 7;

  // comparator p zero means the whole 16-bit range
  localparam logic [CNT_W:0]   PERIOD_FULL = 17'h10000;
  localparam logic [CNT_W-1:0] CNT_RST     = 16'h0000;
  localparam logic [CNT_W-1:0] COMPARATOR_A_VALUE_RST    = 16'h0000;
  localparam logic [COMPARATOR_P_VALUE_W-1:0] COMPARATOR_P_VALUE_ZERO  = 8'h00;

  // output control field codes as seen in pwm and pulse modes
  localparam logic [1:0] OUTCTL_FORCE_INACT = 2'h0;
  localparam logic [1:0] OUTCTL_FORCE_ACT   = 2'h1;
  localparam logic [1:0] OUTCTL_PWM         = 2'h2;
  localparam logic [1:0] OUTCTL_PULSE       = 2'h3;

  // output control field codes as seen in capture mode
  localparam logic [1:0] CAP_RISE = 2'h0;
  localparam logic [1:0] CAP_FALL = 2'h1;
  localparam logic [1:0] CAP_BOTH = 2'h2;
  localparam logic [1:0] CAP_NONE = 2'h3;

  // mode select field, in code order 00, 01, 10, 11
  typedef enum logic [1:0] {
    STPWM_MODE_COMPARE,
    STPWM_MODE_CAPTURE,
    STPWM_MODE_PWM,
    STPWM_MODE_TIMER
  } stpwm_mode_t;

  typedef struct packed {
    stpwm_mode_t        mode_select_field;
    logic [1:0]         output_control_field;
    logic               counter_clear_select;
    logic               period_duty_swap;
    logic               output_initial_level;
    logic               output_polarity;
    logic [COMPARATOR_P_VALUE_W-1:0]  comparator_p_value;
  } stpwm_ctrl_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } stpwm_edge_t;

endpackage : stpwm_pkg

// ---- rtl/stpwm_pin_edge.sv ----
// pin synchroniser with registered edge detection
`timescale 1ns/1ps
`default_nettype none

module stpwm_pin_edge (
  input  wire logic          clock_i,
  input  wire logic          sys_rst_i,
  input  wire logic          pin_i,
  output var  stpwm_pkg::stpwm_edge_t edge_o
);

  typedef struct packed {
    logic                   sync1;
    logic                   sync2;
    logic                   last;
    stpwm_pkg::stpwm_edge_t edge_q;
  } stpwm_pin_state_t;

  stpwm_pin_state_t st;
  stpwm_pin_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // sync1 feeds only sync2; edges are judged on sync2 so each edge yields one event
  always_comb begin
    next_st             = st;
    next_st.sync1       = pin_i;
    next_st.sync2       = st.sync1;
    next_st.last        = st.sync2;
    next_st.edge_q.rise = st.sync2 & ~st.last; // see RQ24
    next_st.edge_q.fall = ~st.sync2 & st.last; // see RQ24
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign edge_o = st.edge_q;

endmodule : stpwm_pin_edge

`default_nettype wire

// ---- rtl/stpwm_tick_gen.sv ----
// timer clock prescaler: one tick per 2**select system clocks
`timescale 1ns/1ps
`default_nettype none

module stpwm_tick_gen #(
  parameter int SEL_W = stpwm_pkg::SEL_W,
  parameter int DIV_W = stpwm_pkg::DIV_W
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic [SEL_W-1:0] clock_select_i,
  output var  logic             tick_o
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic             tick;
  } stpwm_tick_state_t;

  stpwm_tick_state_t st;
  stpwm_tick_state_t next_st;
  logic [DIV_W-1:0]  mask;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    mask         = DIV_W'((DIV_W+1)'(1) << clock_select_i) - DIV_W'(1);
    next_st      = st;
    next_st.div  = st.div + DIV_W'(1);
    next_st.tick = (st.div & mask) == mask;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

endmodule : stpwm_tick_gen

`default_nettype wire

// ---- rtl/stpwm_timer.sv ----
// standard timer: pwm with period/duty swap, single pulse and capture input
// Summary of operation
// RQ1: swap set: period from a, duty p*256
// RQ2: swap set: comparator a match clears counter
// RQ3: pwm generator runs while output forced 00/01
// RQ4: clear select ignored in pwm mode
// RQ5: single pulse when mode 10, output 11
// RQ6: run rising starts counter and pulse
// RQ7: trigger pin edge sets run bit
// RQ8: comparator a match clears run, ends pulse
// RQ9: pulse mode a match raises flag a
// RQ10: pulse counter zeroed only on run rise
// RQ11: pulse mode ignores p, clear, swap
// RQ12: capture mode 01, run rise starts counter
// RQ13: edge select; 11 captures nothing, counts on
// RQ14: capture edge copies counter, raises flag
// RQ15: capture counter runs until run falls
// RQ16: capture p match zeroes counter, flags
// RQ17: capture p zero gives full range
// RQ18: capture pins sampled even when output
// RQ19: capture ignores output bits, drives nothing
// RQ20: pwm output when mode 10, output 10
// RQ21: duty at or above period holds active level
// RQ22: polarity bit inverts pwm output
// RQ23: counter steps once per timer tick
// RQ24: pins synchronised before edge detection
`timescale 1ns/1ps
`default_nettype none

module stpwm_timer #(
  parameter int CNT_W = stpwm_pkg::CNT_W,
  parameter int SEL_W = stpwm_pkg::SEL_W
) (
  input  wire logic                   clock_i,
  input  wire logic                   sys_rst_i,
  input  wire stpwm_pkg::stpwm_ctrl_t ctrl_i,
  input  wire logic [SEL_W-1:0]       clock_select_i,
  input  wire logic                   run_wr_i,
  input  wire logic                   run_wdata_i,
  input  wire logic                   comparator_a_value_wr_i,
  input  wire logic [CNT_W-1:0]       comparator_a_value_wdata_i,
  input  wire logic                   flag_a_clr_i,
  input  wire logic                   flag_p_clr_i,
  input  wire logic                   external_trigger_pin_i,
  input  wire logic                   capture_pin_zero_i,
  input  wire logic                   capture_pin_one_i,
  output var  logic                   timer_out_o,
  output var  logic                   run_bit_o,
  output var  logic [CNT_W-1:0]       counter_o,
  output var  logic [CNT_W-1:0]       comparator_a_value_o,
  output var  logic                   flag_a_o,
  output var  logic                   flag_p_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] comparator_a_value;
    logic             run;
    logic             run_d;
    logic             flag_a;
    logic             flag_p;
    logic             wave;
  } stpwm_state_t;

  stpwm_state_t st;
  stpwm_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////////
  // pin edges and timer tick

  logic                   tick;
  logic [2:0]             pin_raw;
  stpwm_pkg::stpwm_edge_t pin_edge [3];

  assign pin_raw = {capture_pin_one_i, capture_pin_zero_i, external_trigger_pin_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pin
      stpwm_pin_edge u_edge (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (pin_raw[gi]),
        .edge_o    (pin_edge[gi])
      );
    end
  endgenerate

  stpwm_tick_gen #(
    .SEL_W (SEL_W)
  ) u_tick (
    .clock_i        (clock_i),
    .sys_rst_i      (sys_rst_i),
    .clock_select_i (clock_select_i),
    .tick_o         (tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  logic           pwm_mode;
  logic           pulse_mode;
  logic           cap_mode;
  logic           run_rise;
  logic           counting;
  logic [CNT_W:0] cnt_inc;
  logic [CNT_W:0] a_val;
  logic [CNT_W:0] p_val;
  logic [CNT_W:0] period;
  logic [CNT_W:0] duty;
  logic           a_hit;
  logic           p_hit;
  logic           period_hit;
  logic           duty_full;
  logic           pwm_raw;
  logic           act;
  logic           trig_edge;
  logic           cap_edge;
  logic           cap_event;

  always_comb begin
    pwm_mode   = (ctrl_i.mode_select_field == stpwm_pkg::STPWM_MODE_PWM)
               && (ctrl_i.output_control_field != stpwm_pkg::OUTCTL_PULSE); // see RQ20
    pulse_mode = (ctrl_i.mode_select_field == stpwm_pkg::STPWM_MODE_PWM)
               && (ctrl_i.output_control_field == stpwm_pkg::OUTCTL_PULSE); // see RQ5
    cap_mode   = ctrl_i.mode_select_field == stpwm_pkg::STPWM_MODE_CAPTURE; // see RQ12
    run_rise   = st.run & ~st.run_d;
    // the rise cycle only zeroes the counter; stepping starts on the next tick
    counting   = st.run & st.run_d & tick; // see RQ23
    cnt_inc    = {1'b0, st.cnt} + (CNT_W+1)'(1);
    a_val      = {1'b0, st.comparator_a_value};
    // p sets the top byte only over a zero low byte, so it works in steps of 256 counts
    p_val      = (ctrl_i.comparator_p_value == stpwm_pkg::COMPARATOR_P_VALUE_ZERO) ? stpwm_pkg::PERIOD_FULL
               : {1'b0, ctrl_i.comparator_p_value, stpwm_pkg::COMPARATOR_P_VALUE_LSB'(0)}; // see RQ17
    if (ctrl_i.period_duty_swap) begin
      period = a_val; // see RQ1
      duty   = p_val; // see RQ1
    end else begin
      period = p_val;
      duty   = a_val;
    end
    a_hit      = counting & (cnt_inc == a_val);
    p_hit      = counting & (cnt_inc == p_val);
    // clear select takes no part: the period comparator alone ends a cycle
    period_hit = counting & (cnt_inc == period); // see RQ2 RQ4
    duty_full  = duty >= period; // see RQ21
    pwm_raw    = duty_full | ({1'b0, st.cnt} < duty);
    act        = ctrl_i.output_initial_level ^ ctrl_i.output_polarity; // see RQ22
    trig_edge  = pin_edge[0].rise;
    // pins are watched whatever their port direction; software must mask unwanted edges
    unique case (ctrl_i.output_control_field)
      stpwm_pkg::CAP_RISE: cap_edge = pin_edge[1].rise | pin_edge[2].rise; // see RQ13 RQ18
      stpwm_pkg::CAP_FALL: cap_edge = pin_edge[1].fall | pin_edge[2].fall; // see RQ13 RQ18
      stpwm_pkg::CAP_BOTH: cap_edge = pin_edge[1].rise | pin_edge[2].rise
                                    | pin_edge[1].fall | pin_edge[2].fall; // see RQ13 RQ18
      stpwm_pkg::CAP_NONE: cap_edge = 1'b0; // see RQ13
    endcase
    cap_event  = cap_mode & cap_edge; // see RQ14
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st       = st;
    next_st.run_d = st.run;

    // run bit: hardware stop, then trigger start, then software write on top
    if (pulse_mode && a_hit) begin
      next_st.run = 1'b0; // see RQ8
    end
    if (pulse_mode && trig_edge) begin
      next_st.run = 1'b1; // see RQ7
    end
    if (run_wr_i) begin
      next_st.run = run_wdata_i; // see RQ6 RQ15
    end

    // counter
    if (run_rise) begin
      next_st.cnt = stpwm_pkg::CNT_RST; // see RQ6 RQ10 RQ12
    end else if (counting) begin
      if (pwm_mode && period_hit) begin
        next_st.cnt = stpwm_pkg::CNT_RST; // see RQ2
      end else if (cap_mode && p_hit) begin
        next_st.cnt = stpwm_pkg::CNT_RST; // see RQ16 RQ17
      end else begin
        // pulse mode never clears here; it only stops at the a match
        next_st.cnt = cnt_inc[CNT_W-1:0]; // see RQ10 RQ11 RQ15 RQ23
      end
    end

    // comparator a: capture beats a software write in the same cycle
    if (comparator_a_value_wr_i) begin
      next_st.comparator_a_value = comparator_a_value_wdata_i;
    end
    if (cap_event) begin
      next_st.comparator_a_value = st.cnt; // see RQ14
    end

    // request flags: a set in the clearing cycle wins
    next_st.flag_a = (st.flag_a & ~flag_a_clr_i)
                   | ((pwm_mode | pulse_mode) & a_hit) // see RQ9
                   | cap_event; // see RQ14
    next_st.flag_p = (st.flag_p & ~flag_p_clr_i)
                   | ((pwm_mode | cap_mode) & p_hit); // see RQ16

    // output pin; the generator above keeps running whatever is forced here
    if (pwm_mode) begin
      unique case (ctrl_i.output_control_field)
        stpwm_pkg::OUTCTL_FORCE_INACT: next_st.wave = ~act; // see RQ3
        stpwm_pkg::OUTCTL_FORCE_ACT:   next_st.wave = act; // see RQ3
        default:                       next_st.wave = pwm_raw ? act : ~act; // see RQ21 RQ22
      endcase
    end else if (pulse_mode) begin
      next_st.wave = st.run ? act : ~act; // see RQ6 RQ8
    end else begin
      next_st.wave = 1'b0; // see RQ19
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st      <= '0;
      st.cnt  <= stpwm_pkg::CNT_RST;
      st.comparator_a_value <= stpwm_pkg::COMPARATOR_A_VALUE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign timer_out_o          = st.wave;
  assign run_bit_o            = st.run;
  assign counter_o            = st.cnt;
  assign comparator_a_value_o = st.comparator_a_value;
  assign flag_a_o             = st.flag_a;
  assign flag_p_o             = st.flag_p;

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_run_rise;
    st.run && !st.run_d;
  endsequence

  sequence s_pulse_end;
    pulse_mode && a_hit && !run_wr_i && !trig_edge;
  endsequence

  a_run_rise_zero : assert property (s_run_rise |=> st.cnt == '0) // see RQ6
    else $error("counter not zero after run rise");

  a_pwm_swap_clear : assert property ( // see RQ2
    pwm_mode && ctrl_i.period_duty_swap && a_hit && !run_rise |=> st.cnt == '0)
    else $error("a match did not clear pwm counter");

  a_pulse_stop_run : assert property (s_pulse_end |=> !st.run ##1 st.wave != $past(act)) // see RQ8
    else $error("a match did not end the pulse");

  a_pulse_flag_a : assert property (s_pulse_end |=> st.flag_a) // see RQ9
    else $error("flag a missing on pulse end");

  a_trig_sets_run : assert property (pulse_mode && trig_edge && !run_wr_i |=> st.run) // see RQ7
    else $error("trigger edge did not set run");

  a_pulse_hold_cnt : assert property (pulse_mode && !st.run |=> st.cnt == $past(st.cnt)) // see RQ10
    else $error("stopped pulse counter moved");

  a_capture_copy : assert property (cap_event |=> st.comparator_a_value == $past(st.cnt) && st.flag_a) // see RQ14
    else $error("capture did not copy counter");

  a_capture_none : assert property ( // see RQ13
    cap_mode && ctrl_i.output_control_field == stpwm_pkg::CAP_NONE && !comparator_a_value_wr_i
    |=> st.comparator_a_value == $past(st.comparator_a_value))
    else $error("capture taken with edges disabled");

  a_capture_wrap : assert property ( // see RQ16
    cap_mode && p_hit && !run_rise |=> st.cnt == '0 && st.flag_p)
    else $error("p match did not wrap capture counter");

  a_full_duty : assert property ( // see RQ21
    pwm_mode && ctrl_i.output_control_field == stpwm_pkg::OUTCTL_PWM && duty_full
    |=> st.wave == $past(act))
    else $error("full duty not held active");

  a_capture_quiet : assert property (cap_mode |=> !timer_out_o) // see RQ19
    else $error("capture mode drove the output");

  sequence s_pwm_wave;
    pwm_mode && ctrl_i.output_control_field == stpwm_pkg::OUTCTL_PWM && !duty_full;
  endsequence

  a_pwm_p_clear : assert property (pwm_mode && !ctrl_i.period_duty_swap && p_hit |=> st.cnt == '0) // see RQ1
    else $error("p match did not clear pwm counter");

  a_count_step : assert property ( // see RQ23
    counting && !(pwm_mode && period_hit) && !(cap_mode && p_hit)
    |=> st.cnt == CNT_W'($past(cnt_inc)))
    else $error("counter did not step on tick");

  a_count_hold : assert property (!st.run |=> st.cnt == $past(st.cnt)) // see RQ15
    else $error("counter moved while stopped");

  a_pwm_low : assert property (s_pwm_wave ##0 ({1'b0, st.cnt} >= duty) |=> st.wave != $past(act)) // see RQ22
    else $error("pwm output active past duty");

  a_pwm_high : assert property (s_pwm_wave ##0 ({1'b0, st.cnt} < duty) |=> st.wave == $past(act)) // see RQ1 RQ22
    else $error("pwm output inactive within duty");

  a_force_inact : assert property ( // see RQ3
    pwm_mode && ctrl_i.output_control_field == stpwm_pkg::OUTCTL_FORCE_INACT |=> st.wave != $past(act))
    else $error("forced inactive level not held");

  a_force_act : assert property ( // see RQ3
    pwm_mode && ctrl_i.output_control_field == stpwm_pkg::OUTCTL_FORCE_ACT |=> st.wave == $past(act))
    else $error("forced active level not held");

  a_forced_counts : assert property ( // see RQ3 RQ4
    pwm_mode && ctrl_i.output_control_field != stpwm_pkg::OUTCTL_PWM && period_hit |=> st.cnt == '0)
    else $error("forced output stopped the pwm counter");

  a_pulse_lead : assert property (pulse_mode ##0 s_run_rise |=> st.wave == $past(act)) // see RQ6
    else $error("pulse leading edge missing");

  a_pulse_no_p : assert property (pulse_mode && !st.flag_p |=> !st.flag_p) // see RQ11
    else $error("p flag raised in pulse mode");

  a_trig_ignored : assert property (!pulse_mode && trig_edge && !run_wr_i && !st.run |=> !st.run) // see RQ7
    else $error("trigger set run outside pulse mode");

  a_capture_full : assert property ( // see RQ17
    cap_mode && ctrl_i.comparator_p_value == stpwm_pkg::COMPARATOR_P_VALUE_ZERO && counting
    |=> st.cnt == CNT_W'($past(cnt_inc)))
    else $error("capture counter cleared before full range");

  a_flag_p_set : assert property ((pwm_mode || cap_mode) && p_hit |=> st.flag_p) // see RQ16
    else $error("p match did not raise flag p");

  a_comparator_a_value_keep : assert property (!cap_mode && !comparator_a_value_wr_i |=> st.comparator_a_value == $past(st.comparator_a_value)) // see RQ14
    else $error("comparator a changed outside capture");

  a_quiet_other : assert property (!pwm_mode && !pulse_mode |=> !timer_out_o) // see RQ19
    else $error("output driven outside pwm and pulse");

endmodule : stpwm_timer

`default_nettype wire

// ---- tb/stpwm_partner.sv ----
// partner model: external trigger source and capture signal sources
`timescale 1ns/1ps
`default_nettype none

module stpwm_partner (
  input  wire logic clock_i,
  output var  logic trig_o,
  output var  logic cap0_o,
  output var  logic cap1_o
);
  initial begin
    trig_o = 1'b0;
    cap0_o = 1'b0;
    cap1_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // levels change just after an edge and stay put long enough for the synchroniser
  task automatic fire(input logic v);
    @(posedge clock_i);
    trig_o <= v;
  endtask : fire

  task automatic cap(input int idx, input logic v);
    @(posedge clock_i);
    if (idx == 0) begin
      cap0_o <= v;
    end else begin
      cap1_o <= v;
    end
  endtask : cap
endmodule : stpwm_partner
`default_nettype wire

// ---- tb/tb_std_timer_pwm_pulse_capture.sv ----
// testbench: pwm, single pulse and capture behaviour of the standard timer
`timescale 1ns/1ps
`default_nettype none

module tb_std_timer_pwm_pulse_capture;
  logic                   clock_i;
  logic                   sys_rst_i;
  stpwm_pkg::stpwm_ctrl_t ctrl_i;
  logic [2:0]             clock_select_i;
  logic                   run_wr_i;
  logic                   run_wdata_i;
  logic                   comparator_a_value_wr_i;
  logic [15:0]            comparator_a_value_wdata_i;
  logic                   flag_a_clr_i;
  logic                   flag_p_clr_i;
  logic                   trig;
  logic                   cap0;
  logic                   cap1;
  logic                   timer_out_o;
  logic                   run_bit_o;
  logic [15:0]            counter_o;
  logic [15:0]            comparator_a_value_o;
  logic                   flag_a_o;
  logic                   flag_p_o;
  int                     n_mismatch;
  int                     n_tests;
  int                     seed;
  int                     a;
  int                     w;
  int                     per;
  int                     act;
  int                     pd;
  int                     du;
  logic                   lvl;
  logic                   e;
  logic [31:0]            r;
  logic [15:0]            old;

  stpwm_timer DUT (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .ctrl_i(ctrl_i), .clock_select_i(clock_select_i),
    .run_wr_i(run_wr_i), .run_wdata_i(run_wdata_i), .comparator_a_value_wr_i(comparator_a_value_wr_i), .comparator_a_value_wdata_i(comparator_a_value_wdata_i),
    .flag_a_clr_i(flag_a_clr_i), .flag_p_clr_i(flag_p_clr_i), .external_trigger_pin_i(trig),
    .capture_pin_zero_i(cap0), .capture_pin_one_i(cap1), .timer_out_o(timer_out_o),
    .run_bit_o(run_bit_o), .counter_o(counter_o), .comparator_a_value_o(comparator_a_value_o),
    .flag_a_o(flag_a_o), .flag_p_o(flag_p_o));

  stpwm_partner u_partner (.clock_i(clock_i), .trig_o(trig), .cap0_o(cap0), .cap1_o(cap1));

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  task automatic run(input logic v);
    @(posedge clock_i);
    run_wr_i    <= 1'b1;
    run_wdata_i <= v;
    @(posedge clock_i);
    run_wr_i <= 1'b0;
  endtask : run

  task automatic set_a(input logic [15:0] v);
    @(posedge clock_i);
    comparator_a_value_wr_i    <= 1'b1;
    comparator_a_value_wdata_i <= v;
    @(posedge clock_i);
    comparator_a_value_wr_i <= 1'b0;
  endtask : set_a

  task automatic clr();
    @(posedge clock_i);
    flag_a_clr_i <= 1'b1;
    flag_p_clr_i <= 1'b1;
    @(posedge clock_i);
    flag_a_clr_i <= 1'b0;
    flag_p_clr_i <= 1'b0;
  endtask : clr

  // one period from a counter return to zero up to the next, sampled at negedge once flops settle
  task automatic measure(output int p, output int h);
    int   ev;
    logic pz;
    ev = 0;
    pz = 1'b1;
    p  = 0;
    h  = 0;
    for (int i = 0; i < 9000 && ev < 2; i++) begin
      @(negedge clock_i);
      if (counter_o === 16'h0000 && !pz) ev++;
      if (ev == 1) p++;
      if (ev == 1 && timer_out_o === lvl) h++;
      pz = (counter_o === 16'h0000);
    end
    if (ev < 2) begin
      n_mismatch++;
      $display("Error period wait expected edge seen timeout");
      final_report();
    end
  endtask : measure

  task automatic peak(output int m);
    m = 0;
    for (int i = 0; i < 700; i++) begin
      @(negedge clock_i);
      if (int'(counter_o) > m) m = int'(counter_o);
    end
  endtask : peak

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'hbe3c;
    n_mismatch = 0;
    n_tests = 0;
    sys_rst_i = 1'b1;
    ctrl_i = '0;
    clock_select_i = 3'h0;
    run_wr_i = 1'b0;
    run_wdata_i = 1'b0;
    comparator_a_value_wr_i = 1'b0;
    comparator_a_value_wdata_i = 16'h0000;
    flag_a_clr_i = 1'b0;
    flag_p_clr_i = 1'b0;
    tick(16);
    sys_rst_i <= 1'b0;
    tick(1);
    chk("reset counter", 17'h0, 17'(counter_o));
    chk("reset flags", 17'h0, 17'({timer_out_o, run_bit_o, flag_a_o, flag_p_o}));
    // pwm: k0 swap off p=1, k1 swap on p=0, k2 swap on p=1; clear select random
    for (int k = 0; k < 3; k++) begin
      r  = $random(seed);
      a  = 100 + int'(r[15:8]) * 3 % 700;
      pd = (k != 0) ? a : 256;
      du = (k == 0) ? a : ((k == 1) ? 65536 : 256);
      du = (du < pd) ? du : pd;
      lvl = r[2] ^ r[3];
      run(1'b0);
      clock_select_i <= {2'h0, r[0]};
      ctrl_i <= '{stpwm_pkg::STPWM_MODE_PWM, stpwm_pkg::OUTCTL_PWM, r[1], k != 0, r[2], r[3], {7'h0, k != 1}};
      set_a(16'(a));
      run(1'b1);
      for (int j = 0; j < 3; j++) begin
        @(posedge clock_i);
        ctrl_i.output_control_field <= (j == 0) ? stpwm_pkg::OUTCTL_PWM :
          ((j == 1) ? stpwm_pkg::OUTCTL_FORCE_INACT : stpwm_pkg::OUTCTL_FORCE_ACT);
        tick(2);
        measure(per, act);
        chk("pwm period", 17'(pd << r[0]), 17'(per));
        chk("pwm duty", 17'((j == 0) ? du << r[0] : ((j == 1) ? 0 : per)), 17'(act));
      end
    end
    // single pulse: even k by software, odd k by trigger pin; p, swap, clear select random
    clock_select_i <= 3'h0;
    for (int k = 0; k < 4; k++) begin
      r   = $random(seed);
      a   = 5 + int'(r[15:8]) % 30;
      lvl = r[2] ^ r[3];
      run(1'b0);
      ctrl_i <= '{stpwm_pkg::STPWM_MODE_PWM, stpwm_pkg::OUTCTL_PULSE, r[1], r[0], r[2], r[3], r[23:16]};
      set_a(16'(a));
      clr();
      tick(3);
      if (k % 2 == 1) u_partner.fire(1'b1);
      else run(1'b1);
      w = 0;
      for (int i = 0; i < 120; i++) begin
        @(negedge clock_i);
        if (timer_out_o === lvl) w++;
      end
      u_partner.fire(1'b0);
      chk("pulse width", 17'h1, 17'(w == a || w == a + 1));
      chk("pulse run", 17'h0, 17'(run_bit_o));
      chk("pulse flag", 17'h1, 17'(flag_a_o));
      old = counter_o;
      tick(10);
      chk("pulse hold", 17'(old), 17'(counter_o));
      chk("pulse idle", 17'(!lvl), 17'(timer_out_o));
    end
    // capture: every edge code on both pins, rising then falling
    run(1'b0);
    ctrl_i <= '{stpwm_pkg::STPWM_MODE_CAPTURE, stpwm_pkg::CAP_RISE, 1'b1, 1'b1, r[2], ~r[2], 8'h00};
    set_a(16'hffff);
    run(1'b1);
    for (int c = 0; c < 4; c++) begin
      for (int q = 0; q < 4; q++) begin
        ctrl_i.output_control_field <= 2'(c);
        clr();
        old = comparator_a_value_o;
        w   = int'(counter_o);
        e   = (c == 2) || (c == 0 && q % 2 == 0) || (c == 1 && q % 2 == 1);
        u_partner.cap(q / 2, q % 2 == 0);
        tick(8);
        chk("capture taken", 17'(e), 17'(comparator_a_value_o !== old));
        chk("capture flag", 17'(e), 17'(flag_a_o));
        if (e) chk("capture value", 17'h1, 17'((comparator_a_value_o - 16'(w)) <= 16'h0008));
        chk("capture out", 17'h0, 17'(timer_out_o));
      end
    end
    ctrl_i.comparator_p_value <= 8'h01;
    clr();
    peak(w);
    chk("capture p limit", 17'h1, 17'(w < 256 && w > 200));
    chk("capture p flag", 17'h1, 17'(flag_p_o));
    ctrl_i.comparator_p_value <= 8'h00;
    run(1'b0);
    run(1'b1);
    peak(w);
    chk("capture full range", 17'h1, 17'(w > 600));
    run(1'b0);
    tick(2);
    old = counter_o;
    tick(6);
    chk("capture stop", 17'(old), 17'(counter_o));
    final_report();
  end
endmodule : tb_std_timer_pwm_pulse_capture
`default_nettype wire
